// ### common/sad_pkg.sv
// Purpose: constants, types and helpers for the system address decoder
// Assumes: 32-bit byte addresses, two bus masters (core and dma)
// Notes: window sizes are kept as log2 of bytes; bases are byte addresses

package sad_pkg;

  // ==========================================================================
  // sizes
  localparam int SAD_NM = 2;
  localparam int SAD_SLOT_LG = 14;
  localparam int SAD_AHB_SLOT_W = 7;
  localparam int SAD_APB_SLOT_W = 6;

  // ==========================================================================
  // windows
  localparam logic [31:0] SAD_FLASH_BASE = 32'h0000_0000;
  localparam int SAD_FLASH_LG = 19;
  localparam logic [31:0] SAD_FLASH_LAST = (32'h1 << SAD_FLASH_LG) - 32'h1;
  localparam logic [31:0] SAD_MSRAM_BASE = 32'h1000_0000;
  localparam int SAD_MSRAM_LG = 16;
  localparam logic [31:0] SAD_BROM_BASE = 32'h1FFF_0000;
  localparam int SAD_BROM_LG = 13;
  localparam logic [31:0] SAD_PSRAM0_BASE = 32'h2000_0000;
  localparam logic [31:0] SAD_PSRAM1_BASE = 32'h2000_4000;
  localparam int SAD_PSRAM_LG = 14;
  localparam logic [31:0] SAD_AHBP_BASE = 32'h2008_0000;
  localparam int SAD_AHBP_LG = 18;
  localparam logic [31:0] SAD_APBA_BASE = 32'h4000_0000;
  localparam logic [31:0] SAD_APBB_BASE = 32'h4008_0000;
  localparam int SAD_APB_LG = 19;
  localparam logic [3:0][31:0] SAD_ST_BASE = {32'h9C00_0000, 32'h9800_0000, 32'h9000_0000, 32'h8000_0000};
  localparam int SAD_ST_LG = 26;
  localparam logic [31:0] SAD_DY_BASE = 32'hA000_0000;
  localparam logic [3:0] SAD_DY_COUNT = 4'h4;
  localparam logic [31:0] SAD_PPB_BASE = 32'hE000_0000;
  localparam int SAD_PPB_LG = 20;
  // vector area size is not given; 512 bytes covers a full table
  localparam int SAD_VEC_LG = 9;
  localparam logic [31:0] SAD_VEC_MASK = (32'h1 << SAD_VEC_LG) - 32'h1;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    SAD_T_NONE = 4'h0,
    SAD_T_FLASH = 4'h1,
    SAD_T_MSRAM = 4'h2,
    SAD_T_BROM = 4'h3,
    SAD_T_PSRAM0 = 4'h4,
    SAD_T_PSRAM1 = 4'h5,
    SAD_T_AHBP = 4'h6,
    SAD_T_APBA = 4'h7,
    SAD_T_APBB = 4'h8,
    SAD_T_EXT_ST = 4'h9,
    SAD_T_EXT_DY = 4'hA,
    SAD_T_PPB = 4'hB
  } sad_tgt_e;

  typedef enum logic [1:0] {
    SAD_RM_FLASH = 2'h0,
    SAD_RM_BOOT = 2'h1,
    SAD_RM_SRAM = 2'h2,
    SAD_RM_RSVD = 2'h3
  } sad_remap_e;

  typedef struct packed {
    logic strap_done;
    logic [1:0] flash_sz;
    logic [1:0] sram_sz;
    logic prio;
    logic [SAD_NM-1:0] rsp_vld;
    logic [SAD_NM-1:0] rsp_err;
    sad_tgt_e [SAD_NM-1:0] tgt;
    logic [SAD_NM-1:0][SAD_AHB_SLOT_W-1:0] slot;
    logic [SAD_NM-1:0][31:0] addr;
    logic [3:0] st_cs;
    logic [3:0] dy_cs;
  } sad_state_s;

  localparam sad_state_s SAD_STATE_RST = '0;

  // ==========================================================================
  // helpers
  function automatic logic sad_in_win(input logic [31:0] a, input logic [31:0] base, input int lg);
    return ((a ^ base) >> lg) == 32'h0;
  endfunction

  // static and dynamic selects share one external memory port
  function automatic sad_tgt_e sad_port(input sad_tgt_e t);
    return (t == SAD_T_EXT_DY) ? SAD_T_EXT_ST : t;
  endfunction

  function automatic logic [3:0] sad_onehot4(input logic [1:0] idx);
    return 4'h1 << idx;
  endfunction

endpackage

// ### src/sad_decode.sv
// Purpose: combinational decode of one master address into a target
// Assumes: size selects already captured and stable
// Notes: no state; one copy per master
`timescale 1ns/10ps
`default_nettype none

module sad_decode
  import sad_pkg::*;
(
  // request address and configuration
  input wire logic [31:0] addr,
  input wire logic [1:0] flash_sz,
  input wire logic [1:0] sram_sz,
  input wire sad_pkg::sad_remap_e remap,
  // decode result
  output sad_pkg::sad_tgt_e tgt,
  output logic [sad_pkg::SAD_AHB_SLOT_W-1:0] slot,
  output logic [31:0] fwd_addr,
  output logic [1:0] cs_idx
);

  logic st_hit;
  logic [1:0] st_idx;
  logic [3:0] dy_off;
  int sram_shift;

  // ==========================================================================
  // chip select search
  always_comb begin
    st_hit = 1'b0;
    st_idx = 2'h0;
    for (int k = 0; k < 4; k++) begin
      if (sad_in_win(addr, SAD_ST_BASE[k], SAD_ST_LG)) begin
        st_hit = 1'b1;
        st_idx = 2'(k);
      end
    end
    dy_off = addr[31:28] - SAD_DY_BASE[31:28];
    // unused code 3 falls back to the smallest fit
    sram_shift = (sram_sz == 2'h3) ? 2 : int'(sram_sz);
  end

  // ==========================================================================
  // region decode
  always_comb begin
    tgt = SAD_T_NONE;
    slot = '0;
    fwd_addr = addr;
    cs_idx = 2'h0;
    if (sad_in_win(addr, SAD_FLASH_BASE, SAD_VEC_LG) && remap == SAD_RM_BOOT) begin
      tgt = SAD_T_BROM;
      fwd_addr = SAD_BROM_BASE | (addr & SAD_VEC_MASK);
    end else if (sad_in_win(addr, SAD_FLASH_BASE, SAD_VEC_LG) && remap == SAD_RM_SRAM) begin
      tgt = SAD_T_MSRAM;
      fwd_addr = SAD_MSRAM_BASE | (addr & SAD_VEC_MASK);
    end else if (sad_in_win(addr, SAD_FLASH_BASE, SAD_FLASH_LG - int'(flash_sz))) begin
      tgt = SAD_T_FLASH;
    end else if (sad_in_win(addr, SAD_MSRAM_BASE, SAD_MSRAM_LG - sram_shift)) begin
      tgt = SAD_T_MSRAM;
    end else if (sad_in_win(addr, SAD_BROM_BASE, SAD_BROM_LG)) begin
      tgt = SAD_T_BROM;
    end else if (sad_in_win(addr, SAD_PSRAM0_BASE, SAD_PSRAM_LG)) begin
      tgt = SAD_T_PSRAM0;
    end else if (sad_in_win(addr, SAD_PSRAM1_BASE, SAD_PSRAM_LG)) begin
      tgt = SAD_T_PSRAM1;
    end else if (sad_in_win(addr, SAD_AHBP_BASE, SAD_AHBP_LG)) begin
      tgt = SAD_T_AHBP;
      slot = addr[SAD_SLOT_LG +: SAD_AHB_SLOT_W];
    end else if (sad_in_win(addr, SAD_APBA_BASE, SAD_APB_LG)) begin
      tgt = SAD_T_APBA;
      slot = {1'b0, addr[SAD_SLOT_LG +: SAD_APB_SLOT_W]};
    end else if (sad_in_win(addr, SAD_APBB_BASE, SAD_APB_LG)) begin
      tgt = SAD_T_APBB;
      slot = {1'b0, addr[SAD_SLOT_LG +: SAD_APB_SLOT_W]};
    end else if (st_hit) begin
      tgt = SAD_T_EXT_ST;
      cs_idx = st_idx;
    end else if (dy_off < SAD_DY_COUNT) begin
      tgt = SAD_T_EXT_DY;
      cs_idx = dy_off[1:0];
    end else if (sad_in_win(addr, SAD_PPB_BASE, SAD_PPB_LG)) begin
      tgt = SAD_T_PPB;
    end
  end

endmodule // sad_decode

`default_nettype wire

// ### src/sad_top.sv
// Purpose: system address decoder for two bus masters
// Assumes: inputs synchronous to mclk; size selects stable at reset release
// Notes: answers come one cycle after a request is taken
`timescale 1ns/10ps
`default_nettype none

module sad_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // size selects, caught once after reset
  input wire logic [1:0] flash_size_sel,
  input wire logic [1:0] sram_size_sel,
  // vector area remap setting
  input wire sad_pkg::sad_remap_e remap_sel,
  // master requests, index 0 core, index 1 dma
  input wire logic [sad_pkg::SAD_NM-1:0] m_valid,
  input wire logic [sad_pkg::SAD_NM-1:0][31:0] m_addr,
  output logic [sad_pkg::SAD_NM-1:0] m_ready,
  // per-master answers
  output logic [sad_pkg::SAD_NM-1:0] r_valid,
  output logic [sad_pkg::SAD_NM-1:0] r_err,
  output sad_pkg::sad_tgt_e [sad_pkg::SAD_NM-1:0] r_tgt,
  output logic [sad_pkg::SAD_NM-1:0][sad_pkg::SAD_AHB_SLOT_W-1:0] r_slot,
  output logic [sad_pkg::SAD_NM-1:0][31:0] r_addr,
  // external memory chip selects
  output logic [3:0] st_cs,
  output logic [3:0] dy_cs
);
  import sad_pkg::*;

  sad_state_s st_q;
  sad_state_s st_d;
  sad_tgt_e [SAD_NM-1:0] dec_tgt;
  logic [SAD_NM-1:0][SAD_AHB_SLOT_W-1:0] dec_slot;
  logic [SAD_NM-1:0][31:0] dec_addr;
  logic [SAD_NM-1:0][1:0] dec_cs;
  logic [SAD_NM-1:0] take;
  logic conflict;

  // ==========================================================================
  // decode, one per master
  for (genvar g = 0; g < SAD_NM; g++) begin : g_dec
    sad_decode u_dec (
      .addr(m_addr[g]),
      .flash_sz(st_q.flash_sz),
      .sram_sz(st_q.sram_sz),
      .remap(remap_sel),
      .tgt(dec_tgt[g]),
      .slot(dec_slot[g]),
      .fwd_addr(dec_addr[g]),
      .cs_idx(dec_cs[g])
    );
  end

  // ==========================================================================
  // arbitration
  // only two masters on one slave port collide; unmapped never collides
  assign conflict = (&m_valid) && (dec_tgt[0] != SAD_T_NONE) &&
                    (sad_port(dec_tgt[0]) == sad_port(dec_tgt[1]));

  // alternating priority trades a little logic for no starvation of the dma
  always_comb begin
    for (int i = 0; i < SAD_NM; i++) begin
      m_ready[i] = st_q.strap_done && !(conflict && (st_q.prio != i[0]));
    end
  end

  assign take = m_valid & m_ready;

  // ==========================================================================
  // next state
  always_comb begin
    st_d = st_q;
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.flash_sz = flash_size_sel;
      st_d.sram_sz = sram_size_sel;
    end
    if (conflict && st_q.strap_done) begin
      st_d.prio = ~st_q.prio;
    end
    st_d.st_cs = 4'h0;
    st_d.dy_cs = 4'h0;
    for (int i = 0; i < SAD_NM; i++) begin
      st_d.rsp_vld[i] = take[i];
      st_d.rsp_err[i] = take[i] && (dec_tgt[i] == SAD_T_NONE);
      st_d.tgt[i] = take[i] ? dec_tgt[i] : SAD_T_NONE;
      if (take[i]) begin
        st_d.slot[i] = dec_slot[i];
        st_d.addr[i] = dec_addr[i];
      end
      if (take[i] && dec_tgt[i] == SAD_T_EXT_ST) begin
        st_d.st_cs = st_d.st_cs | sad_onehot4(dec_cs[i]);
      end
      if (take[i] && dec_tgt[i] == SAD_T_EXT_DY) begin
        st_d.dy_cs = st_d.dy_cs | sad_onehot4(dec_cs[i]);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SAD_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  assign r_valid = st_q.rsp_vld;
  assign r_err = st_q.rsp_err;
  assign r_tgt = st_q.tgt;
  assign r_slot = st_q.slot;
  assign r_addr = st_q.addr;
  assign st_cs = st_q.st_cs;
  assign dy_cs = st_q.dy_cs;

  // ==========================================================================
  // checks, watched on master 0 except the sharing and dma fairness checks
  logic [31:0] a0;
  assign a0 = m_addr[0];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  flash_top_a: assert property (
    take[0] && (a0 | 32'h3) == SAD_FLASH_LAST && st_q.flash_sz == 2'h0 |=> r_tgt[0] == SAD_T_FLASH && !r_err[0])
    else $error("top of largest flash window not routed to flash");

  flash_shrink_a: assert property (
    take[0] && a0 == ((SAD_FLASH_LAST >> 1) + 32'h1) && st_q.flash_sz == 2'h1 |=> r_err[0])
    else $error("address past a halved flash window was not refused");

  msram_win_a: assert property (
    take[0] && sad_in_win(a0, SAD_MSRAM_BASE, SAD_MSRAM_LG) && st_q.sram_sz == 2'h0
    |=> r_tgt[0] == SAD_T_MSRAM)
    else $error("main sram window misrouted");

  boot_rom_a: assert property (
    take[0] && sad_in_win(a0, SAD_BROM_BASE, SAD_BROM_LG)
    |=> r_tgt[0] == SAD_T_BROM && r_addr[0] == $past(a0))
    else $error("boot rom window misrouted");

  psram_bank_a: assert property (
    take[0] && sad_in_win(a0, SAD_PSRAM0_BASE, SAD_PSRAM_LG + 1)
    |=> r_tgt[0] == ($past(a0[SAD_PSRAM_LG]) ? SAD_T_PSRAM1 : SAD_T_PSRAM0))
    else $error("peripheral sram bank chosen wrongly");

  ahb_slot_a: assert property (
    take[0] && sad_in_win(a0, SAD_AHBP_BASE, SAD_AHBP_LG)
    |=> r_tgt[0] == SAD_T_AHBP && r_slot[0] == 7'($past(a0) >> SAD_SLOT_LG))
    else $error("high-speed peripheral slot wrong");

  apb_slot_a: assert property (
    take[0] && sad_in_win(a0, SAD_APBA_BASE, SAD_APB_LG + 1)
    |=> r_tgt[0] == ($past(a0[SAD_APB_LG]) ? SAD_T_APBB : SAD_T_APBA)
        && r_slot[0] == 7'($past(a0) >> SAD_SLOT_LG))
    else $error("low-speed peripheral segment or slot wrong");

  static_cs0_a: assert property (
    take[0] && sad_in_win(a0, SAD_ST_BASE[0], SAD_ST_LG) |=> st_cs == 4'h1 && dy_cs == 4'h0)
    else $error("static select 0 not alone");

  static_cs3_a: assert property (
    take[0] && sad_in_win(a0, SAD_ST_BASE[3], SAD_ST_LG) |=> st_cs == 4'h8 ##1 (st_cs == 4'h0 || $past(|take)))
    else $error("static select 3 wrong or held too long");

  dyn_cs_a: assert property (
    take[0] && (a0[31:28] - SAD_DY_BASE[31:28]) == 4'h3 |=> dy_cs == 4'h8 && st_cs == 4'h0)
    else $error("dynamic select 3 wrong");

  ppb_win_a: assert property (
    take[0] && sad_in_win(a0, SAD_PPB_BASE, SAD_PPB_LG) |=> r_tgt[0] == SAD_T_PPB)
    else $error("private peripheral window misrouted");

  vec_remap_a: assert property (
    take[0] && sad_in_win(a0, SAD_FLASH_BASE, SAD_VEC_LG) && remap_sel == SAD_RM_SRAM
    |=> r_tgt[0] == SAD_T_MSRAM && r_addr[0] == (SAD_MSRAM_BASE | $past(a0)))
    else $error("vector area not redirected to main sram");

  ram_concur_a: assert property (
    (&m_valid) && st_q.strap_done && sad_port(dec_tgt[0]) != sad_port(dec_tgt[1])
    |-> (&m_ready) ##1 (&r_valid))
    else $error("masters on different slaves stalled each other");

  dma_fair_a: assert property (
    m_valid[1] && !m_ready[1] && st_q.strap_done ##1 m_valid[1] |-> m_ready[1])
    else $error("dma refused twice in a row");

  unmapped_a: assert property (
    take[0] && a0[31:28] == 4'hF |=> r_err[0] && r_valid[0] && r_tgt[0] == SAD_T_NONE)
    else $error("unmapped address not answered with error");

  both_taken_c: cover property ((&take) && dec_tgt[0] != dec_tgt[1]);
  conflict_c: cover property (conflict ##1 conflict);
  err_c: cover property (r_err[0]);
  remap_boot_c: cover property (take[0] && remap_sel == SAD_RM_BOOT && sad_in_win(a0, SAD_FLASH_BASE, SAD_VEC_LG));

endmodule // sad_top

`default_nettype wire

// ### bench/sad_master_model.sv
// Purpose: bus master model for one request port of the address decoder
// Assumes: the bench calls put and drop on the falling edge of mclk
// Notes: a dropped request shows the inverse address, so a stale value never looks valid
`timescale 1ns/10ps
`default_nettype none

module sad_master_model (
  // request port
  output logic valid,
  output logic [31:0] addr
);
  initial begin
    valid = 1'b0;
    addr = 32'h0;
  end

  // ==========================================================================
  // request control
  // a refused request stays up unchanged until the decoder takes it
  task automatic put(input logic [31:0] a);
    valid <= 1'b1;
    addr <= a;
  endtask

  task automatic drop();
    valid <= 1'b0;
    addr <= ~addr;
  endtask
endmodule // sad_master_model
`default_nettype wire

// ### bench/sad_tb_top.sv
// Purpose: self-checking bench for the system address decoder
// Assumes: two master models, inputs changed on the falling edge of mclk
// Notes: expectations come from the address map, never from the decoder outputs
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin n_errors++; $display("Error %0t: %s", $time, m); end end

module sad_tb_top;
  import sad_pkg::*;
  typedef struct packed {logic [31:0] a; sad_tgt_e t; logic [6:0] s; logic [3:0] cs;} sad_row_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] fsz = 2'h0;
  logic [1:0] ssz = 2'h0;
  sad_remap_e remap = SAD_RM_FLASH;
  // each master model drives its own slice, so these are nets
  wire logic [SAD_NM-1:0] m_valid;
  wire logic [SAD_NM-1:0][31:0] m_addr;
  logic [SAD_NM-1:0] m_ready, r_valid, r_err;
  logic [SAD_NM-1:0][31:0] r_addr;
  logic [SAD_NM-1:0][SAD_AHB_SLOT_W-1:0] r_slot;
  sad_tgt_e [SAD_NM-1:0] r_tgt;
  logic [3:0] st_cs, dy_cs;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  sad_row_s rows[$];

  // ==========================================================================
  // design and masters
  sad_master_model mst0 (.valid(m_valid[0]), .addr(m_addr[0]));
  sad_master_model mst1 (.valid(m_valid[1]), .addr(m_addr[1]));
  sad_top dut (.mclk(mclk), .rst_n(rst_n), .flash_size_sel(fsz), .sram_size_sel(ssz), .remap_sel(remap),
    .m_valid(m_valid), .m_addr(m_addr), .m_ready(m_ready), .r_valid(r_valid), .r_err(r_err), .r_tgt(r_tgt),
    .r_slot(r_slot), .r_addr(r_addr), .st_cs(st_cs), .dy_cs(dy_cs));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // a hang is cut short well beyond the roughly 160 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  // ==========================================================================
  // tasks
  task automatic stop_test();
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] f, input logic [1:0] s);
    @(negedge mclk);
    rst_n = 1'b0;
    fsz = f;
    ssz = s;
    repeat (6) @(negedge mclk);
    `CHK(m_ready, 2'b00, "ready during reset")
    `CHK({r_valid, r_err, st_cs, dy_cs}, 12'h000, "outputs during reset")
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
  endtask

  task automatic r(input logic [31:0] a, input sad_tgt_e t, input logic [6:0] s, input logic [3:0] cs);
    rows.push_back({a, t, s, cs});
  endtask

  task automatic xfer(input int m, input logic [31:0] a, input sad_tgt_e t, input logic [6:0] s,
    input logic [31:0] fa, input logic [3:0] cs);
    int n;
    n = 0;
    @(negedge mclk);
    `CHK({r_valid, r_err, r_tgt, st_cs, dy_cs}, 20'h00000, "answer longer than one cycle")
    if (m == 1) begin
      mst1.put(a);
    end else begin
      mst0.put(a);
    end
    #45;
    while (m_ready[m] !== 1'b1 && n < 8) begin
      @(negedge mclk);
      #45;
      n++;
    end
    `CHK(m_ready[m], 1'b1, "request not taken")
    @(negedge mclk);
    if (m == 1) begin
      mst1.drop();
    end else begin
      mst0.drop();
    end
    `CHK(r_valid[m], 1'b1, "no answer")
    `CHK(r_valid[1-m], 1'b0, "answer on idle master")
    `CHK(r_tgt[m], t, "wrong target")
    `CHK(r_err[m], t == SAD_T_NONE, "wrong error flag")
    `CHK(st_cs, (t == SAD_T_EXT_ST) ? cs : 4'h0, "wrong static select")
    `CHK(dy_cs, (t == SAD_T_EXT_DY) ? cs : 4'h0, "wrong dynamic select")
    if (t != SAD_T_NONE) begin
      `CHK(r_slot[m], s, "wrong slot")
      `CHK(r_addr[m], fa, "wrong forwarded address")
    end
  endtask

  task automatic both(input logic [31:0] a0, input logic [31:0] a1, input logic [1:0] rdy, input logic [1:0] rv);
    @(negedge mclk);
    `CHK(r_valid, rv, "wrong answers while sharing")
    mst0.put(a0);
    mst1.put(a1);
    #45;
    `CHK(m_ready, rdy, "wrong grant pattern")
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] ms;
    r(32'h0000_1000, SAD_T_FLASH, 7'h00, 4'h0);
    r(32'h0007_FFFC, SAD_T_FLASH, 7'h00, 4'h0);
    r(32'h0008_0000, SAD_T_NONE, 7'h00, 4'h0);
    r(32'h1000_0000, SAD_T_MSRAM, 7'h00, 4'h0);
    r(32'h1000_FFFC, SAD_T_MSRAM, 7'h00, 4'h0);
    r(32'h1001_0000, SAD_T_NONE, 7'h00, 4'h0);
    r(32'h1FFF_0000, SAD_T_BROM, 7'h00, 4'h0);
    r(32'h1FFF_1FFC, SAD_T_BROM, 7'h00, 4'h0);
    r(32'h1FFF_2000, SAD_T_NONE, 7'h00, 4'h0);
    r(32'h2000_0000, SAD_T_PSRAM0, 7'h00, 4'h0);
    r(32'h2000_3FFC, SAD_T_PSRAM0, 7'h00, 4'h0);
    r(32'h2000_4000, SAD_T_PSRAM1, 7'h00, 4'h0);
    r(32'h2000_7FFC, SAD_T_PSRAM1, 7'h00, 4'h0);
    r(32'h2000_8000, SAD_T_NONE, 7'h00, 4'h0);
    r(32'h2008_0000, SAD_T_AHBP, 7'h20, 4'h0);
    r(32'h200B_FFFC, SAD_T_AHBP, 7'h2F, 4'h0);
    r(32'h200C_0000, SAD_T_NONE, 7'h00, 4'h0);
    r(32'h4000_0000, SAD_T_APBA, 7'h00, 4'h0);
    r(32'h4007_C000, SAD_T_APBA, 7'h1F, 4'h0);
    r(32'h4008_0000, SAD_T_APBB, 7'h20, 4'h0);
    r(32'h400F_FFFC, SAD_T_APBB, 7'h3F, 4'h0);
    r(32'h4010_0000, SAD_T_NONE, 7'h00, 4'h0);
    r(32'h8000_0000, SAD_T_EXT_ST, 7'h00, 4'h1);
    r(32'h83FF_FFFC, SAD_T_EXT_ST, 7'h00, 4'h1);
    r(32'h8400_0000, SAD_T_NONE, 7'h00, 4'h0);
    r(32'h9000_0000, SAD_T_EXT_ST, 7'h00, 4'h2);
    r(32'h9FFF_FFFC, SAD_T_EXT_ST, 7'h00, 4'h8);
    r(32'h9800_0000, SAD_T_EXT_ST, 7'h00, 4'h4);
    r(32'hA000_0000, SAD_T_EXT_DY, 7'h00, 4'h1);
    r(32'hBFFF_FFFC, SAD_T_EXT_DY, 7'h00, 4'h2);
    r(32'hDFFF_FFFC, SAD_T_EXT_DY, 7'h00, 4'h8);
    r(32'hC000_0000, SAD_T_EXT_DY, 7'h00, 4'h4);
    r(32'hE000_0000, SAD_T_PPB, 7'h00, 4'h0);
    r(32'hE00F_FFFC, SAD_T_PPB, 7'h00, 4'h0);
    r(32'hE010_0000, SAD_T_NONE, 7'h00, 4'h0);
    do_reset(2'h0, 2'h0);
    foreach (rows[i]) begin
      xfer(i % 2, rows[i].a, rows[i].t, rows[i].s, rows[i].a, rows[i].cs);
    end
    // every size code, each behind a fresh reset since straps are caught once
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1:0], k[1:0]);
      ms = 32'h1000_0000 + (32'h1_0000 >> ((k > 2) ? 2 : k));
      xfer(0, (32'h8_0000 >> k) - 32'h4, SAD_T_FLASH, 7'h00, (32'h8_0000 >> k) - 32'h4, 4'h0);
      xfer(0, 32'h8_0000 >> k, SAD_T_NONE, 7'h00, 32'h0, 4'h0);
      xfer(0, ms - 32'h4, SAD_T_MSRAM, 7'h00, ms - 32'h4, 4'h0);
      xfer(1, ms, SAD_T_NONE, 7'h00, 32'h0, 4'h0);
    end
    remap = SAD_RM_BOOT;
    xfer(0, 32'h104, SAD_T_BROM, 7'h00, 32'h1FFF_0104, 4'h0);
    xfer(1, 32'h200, SAD_T_FLASH, 7'h00, 32'h200, 4'h0);
    remap = SAD_RM_SRAM;
    xfer(0, 32'h1FC, SAD_T_MSRAM, 7'h00, 32'h1000_01FC, 4'h0);
    remap = SAD_RM_RSVD;
    xfer(0, 32'h4, SAD_T_FLASH, 7'h00, 32'h4, 4'h0);
    // same ram or static beside dynamic collides and alternates; other different rams and unmapped run side by side
    both(32'h1000_0000, 32'h1000_0000, 2'b01, 2'b00);
    both(32'h1000_0004, 32'h1000_0000, 2'b10, 2'b01);
    both(32'h1000_0004, 32'h2000_0000, 2'b11, 2'b10);
    both(32'h8000_0000, 32'hA000_0000, 2'b01, 2'b11);
    both(32'hF000_0000, 32'hA000_0000, 2'b11, 2'b01);
    @(negedge mclk);
    mst0.drop();
    mst1.drop();
    `CHK(r_valid, 2'b11, "side by side answers")
    `CHK(r_err, 2'b01, "unmapped error beside dynamic")
    `CHK(r_tgt[1], SAD_T_EXT_DY, "dynamic target")
    `CHK({st_cs, dy_cs}, 8'h01, "selects beside unmapped")
    stop_test();
  end
endmodule // sad_tb_top
`default_nettype wire
